/* File: logic/pspc_regs.vh */
/*
 port s pin configuration: register offsets, field positions, reset values and timing counts.
 assumes a plain register port with 4-bit address and 8-bit data.
*/
`ifndef PSPC_REGS_VH
`define PSPC_REGS_VH

`define PSPC_ADDR_W 4
`define PSPC_DATA_W 8

`define PSPC_OFS_DATA 4'h0
`define PSPC_OFS_INPUT 4'h1
`define PSPC_OFS_DIRECTION 4'h2
`define PSPC_OFS_PULL_ENABLE 4'h3
`define PSPC_OFS_PULL_POLARITY 4'h4
`define PSPC_OFS_OPEN_DRAIN 4'h5
`define PSPC_OFS_ROUTING 4'h6
`define PSPC_OFS_EDGE_FLAG 4'h7
`define PSPC_OFS_IRQ_MASK 4'h8

`define PSPC_RST_DATA 8'h00
`define PSPC_RST_DIRECTION 8'h00
`define PSPC_RST_PULL_ENABLE 8'hff
`define PSPC_RST_PULL_POLARITY 8'h00
`define PSPC_RST_OPEN_DRAIN 8'h00
`define PSPC_RST_ROUTING 8'h00
`define PSPC_RST_EDGE_FLAG 8'h00
`define PSPC_RST_IRQ_MASK 8'h00

`define PSPC_ROUTE_IIC_HI 1
`define PSPC_ROUTE_IIC_LO 0
`define PSPC_ROUTE_SPI_HI 5
`define PSPC_ROUTE_SPI_LO 4
`define PSPC_ROUTING_MASK 8'h33

`define PSPC_IIC_PORT_R 2'h2
`define PSPC_IIC_PORT_V 2'h3
`define PSPC_SPI_PORT_S 2'h0
`define PSPC_SPI_PORT_H 2'h1
`define PSPC_SPI_PORT_V 2'h2
`define PSPC_SPI_RESERVED 2'h3

`define PSPC_SYNC_STAGES 2

`endif

/* File: logic/pspc_sync.v */
/*
 two-stage synchroniser for the port s pin inputs, one chain per bit.
 assumes pins are asynchronous to clk; only the last stage may be read.
*/
`timescale 1ns/10ps
module pspc_sync #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// asynchronous input and synchronised output
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_r;
			reg stable_r;
			always @(posedge clk) begin
				if (sys_rst) begin
					meta_r <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r <= async_in[i];
					stable_r <= meta_r;
				end
			end
			assign sync_out[i] = stable_r;
		end
	endgenerate

endmodule

/* File: logic/pspc_pad.v */
/*
 per-pin pad control: turns effective direction, value and buffer mode into drive and pulls.
 assumes the caller registers every result before it leaves the block.
*/
`timescale 1ns/10ps
module pspc_pad #(
	parameter WIDTH = 8
) (
	// resolved per-pin function
	input wire [WIDTH-1:0] drive_out,
	input wire [WIDTH-1:0] out_value,
	input wire [WIDTH-1:0] open_drain,
	// pull configuration
	input wire [WIDTH-1:0] pull_enable,
	input wire [WIDTH-1:0] pull_polarity,
	// pad controls
	output wire [WIDTH-1:0] pad_out,
	output wire [WIDTH-1:0] pad_oe,
	output wire [WIDTH-1:0] pad_pull_up,
	output wire [WIDTH-1:0] pad_pull_dn
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			wire od_active;
			// open-drain only matters while the pin drives
			assign od_active = drive_out[i] & open_drain[i];
			// open-drain releases the pin instead of driving a high
			assign pad_oe[i] = drive_out[i] & ~(od_active & out_value[i]);
			assign pad_out[i] = od_active ? 1'b0 : out_value[i];
			assign pad_pull_dn[i] = ~drive_out[i] & pull_enable[i] & pull_polarity[i];
			assign pad_pull_up[i] = ~drive_out[i] & pull_enable[i] & ~pull_polarity[i];
		end
	endgenerate

endmodule

/* File: logic/pspc_top.v */
/*
 port s pin configuration: registers, peripheral direction overrides, pad control,
 module routing decode, edge flags and the interrupt.
 assumes peripheral inputs are on clk; pins are asynchronous and are synchronised here.
 assumes software accepts that a data read follows the direction register, not the
 resolved direction, so a pin owned by a peripheral reads like a general purpose pin.
*/
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "pspc_regs.vh"
module pspc_top #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register port
	input wire [`PSPC_ADDR_W-1:0] reg_addr,
	input wire [`PSPC_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`PSPC_DATA_W-1:0] reg_rdata,
	// pins
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_out,
	output reg [WIDTH-1:0] pin_oe,
	output reg [WIDTH-1:0] pin_pull_up,
	output reg [WIDTH-1:0] pin_pull_dn,
	output reg [WIDTH-1:0] pin_sync,
	// can on pins 3 and 2
	input wire can_en,
	input wire can_tx,
	// serial_comm_interface on pins 1 and 0
	input wire serial_comm_interface_en,
	input wire serial_comm_interface_txd,
	// pwm_channel_seven on pin 1
	input wire pwm_channel_seven_routed,
	input wire pwm_channel_seven_shutdown,
	input wire pwm_channel_seven_out,
	// pwm_channel_six on pin 0
	input wire pwm_channel_six_routed,
	input wire pwm_channel_six_en,
	input wire pwm_channel_six_out,
	// spi on pins 4 to 7
	input wire spi_en,
	input wire [3:0] spi_oe,
	input wire [3:0] spi_out,
	// iic on pins 4 and 7
	input wire iic_en,
	input wire iic_scl_out,
	input wire iic_sda_out,
	// pwm channels 0 to 3 on pins 4 to 7
	input wire [3:0] pwm_low_routed,
	input wire [3:0] pwm_low_en,
	input wire [3:0] pwm_low_out,
	// routing results
	output reg iic_on_port_s,
	output reg iic_on_port_r,
	output reg iic_on_port_v,
	output reg spi_on_port_s,
	output reg spi_on_port_h,
	output reg spi_on_port_v,
	output reg spi_route_reserved,
	// interrupt
	output reg irq
);

	reg [WIDTH-1:0] data_r;
	reg [WIDTH-1:0] direction_r;
	reg [WIDTH-1:0] pull_enable_r;
	reg [WIDTH-1:0] pull_polarity_r;
	reg [WIDTH-1:0] open_drain_r;
	reg [`PSPC_DATA_W-1:0] routing_r;
	reg [WIDTH-1:0] edge_flag_r;
	reg [WIDTH-1:0] edge_flag_nxt;
	reg [WIDTH-1:0] irq_mask_r;
	reg [WIDTH-1:0] pin_prev_r;
	reg [`PSPC_DATA_W-1:0] rdata_nxt;

	reg [WIDTH-1:0] drive_nxt;
	reg [WIDTH-1:0] value_nxt;
	reg [WIDTH-1:0] force_od_nxt;

	wire [WIDTH-1:0] pin_s;
	wire [WIDTH-1:0] pad_out_w;
	wire [WIDTH-1:0] pad_oe_w;
	wire [WIDTH-1:0] pad_pu_w;
	wire [WIDTH-1:0] pad_pd_w;
	wire [WIDTH-1:0] rise_seen;
	wire [WIDTH-1:0] fall_seen;
	wire [WIDTH-1:0] edge_seen;
	wire [WIDTH-1:0] flag_clear;
	wire [1:0] iic_route;
	wire [1:0] spi_route;
	wire spi_here;
	wire iic_here;
	wire wr_hit_flag;
	integer k;

	// fixed pin positions of the peripherals that share port s
	localparam PIN_SCI_RX = 0;
	localparam PIN_SCI_TX = 1;
	localparam PIN_CAN_RX = 2;
	localparam PIN_CAN_TX = 3;
	localparam PIN_UPPER = 4;
	localparam UPPER_COUNT = 4;
	localparam IIC_SCL_SLOT = 0;
	localparam IIC_SDA_SLOT = 3;

	assign iic_route = routing_r[`PSPC_ROUTE_IIC_HI:`PSPC_ROUTE_IIC_LO];
	assign spi_route = routing_r[`PSPC_ROUTE_SPI_HI:`PSPC_ROUTE_SPI_LO];
	assign wr_hit_flag = reg_wr && (reg_addr == `PSPC_OFS_EDGE_FLAG);

	// spi owns port s for code 00; iic for 00 and 01
	assign spi_here = spi_en && (spi_route == `PSPC_SPI_PORT_S);
	assign iic_here = iic_en && !iic_route[1];

	// two flops only: a read just after a direction change may still show the old level
	pspc_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(pin_in),
		.sync_out(pin_s)
	);

	// register file; every write lands on the next edge
	always @(posedge clk) begin
		if (sys_rst) begin
			data_r <= `PSPC_RST_DATA;
			direction_r <= `PSPC_RST_DIRECTION;
			pull_enable_r <= `PSPC_RST_PULL_ENABLE;
			pull_polarity_r <= `PSPC_RST_PULL_POLARITY;
			open_drain_r <= `PSPC_RST_OPEN_DRAIN;
			routing_r <= `PSPC_RST_ROUTING;
			irq_mask_r <= `PSPC_RST_IRQ_MASK;
		end else if (reg_wr) begin
			case (reg_addr)
			`PSPC_OFS_DATA: begin
				data_r <= reg_wdata;
			end
			`PSPC_OFS_DIRECTION: begin
				direction_r <= reg_wdata;
			end
			`PSPC_OFS_PULL_ENABLE: begin
				pull_enable_r <= reg_wdata;
			end
			`PSPC_OFS_PULL_POLARITY: begin
				pull_polarity_r <= reg_wdata;
			end
			`PSPC_OFS_OPEN_DRAIN: begin
				open_drain_r <= reg_wdata;
			end
			`PSPC_OFS_ROUTING: begin
				// unused routing bits are not stored and read as zero
				routing_r <= reg_wdata & `PSPC_ROUTING_MASK;
			end
			`PSPC_OFS_IRQ_MASK: begin
				irq_mask_r <= reg_wdata;
			end
			default: begin
				// input index, edge flag and unmapped indices store nothing here
				irq_mask_r <= irq_mask_r;
			end
			endcase
		end
	end

	// direction and value resolution, highest priority first
	always @* begin
		drive_nxt = direction_r;
		value_nxt = data_r;
		force_od_nxt = {WIDTH{1'b0}};

		// pin 0: serial receive, then pwm_channel_six
		if (serial_comm_interface_en) begin
			drive_nxt[PIN_SCI_RX] = 1'b0;
		end else if (pwm_channel_six_routed && pwm_channel_six_en) begin
			drive_nxt[PIN_SCI_RX] = 1'b1;
			value_nxt[PIN_SCI_RX] = pwm_channel_six_out;
		end

		// pin 1: serial transmit, then pwm_channel_seven as shutdown sense or output
		if (serial_comm_interface_en) begin
			drive_nxt[PIN_SCI_TX] = 1'b1;
			value_nxt[PIN_SCI_TX] = serial_comm_interface_txd;
		end else if (pwm_channel_seven_routed && pwm_channel_seven_shutdown) begin
			// shutdown sense must never fight the external source
			drive_nxt[PIN_SCI_TX] = 1'b0;
		end else if (pwm_channel_seven_routed) begin
			drive_nxt[PIN_SCI_TX] = 1'b1;
			value_nxt[PIN_SCI_TX] = pwm_channel_seven_out;
		end

		// can takes pins 3 and 2 whatever the direction bits say
		if (can_en) begin
			drive_nxt[PIN_CAN_RX] = 1'b0;
			drive_nxt[PIN_CAN_TX] = 1'b1;
			value_nxt[PIN_CAN_TX] = can_tx;
		end

		// upper pins: spi, then iic as open-drain, then the low pwm channels
		for (k = 0; k < UPPER_COUNT; k = k + 1) begin
			if (spi_here) begin
				drive_nxt[k+PIN_UPPER] = spi_oe[k];
				value_nxt[k+PIN_UPPER] = spi_out[k];
			end else if (iic_here && (k == IIC_SCL_SLOT || k == IIC_SDA_SLOT)) begin
				drive_nxt[k+PIN_UPPER] = 1'b1;
				force_od_nxt[k+PIN_UPPER] = 1'b1;
				value_nxt[k+PIN_UPPER] = (k == IIC_SCL_SLOT) ? iic_scl_out : iic_sda_out;
			end else if (pwm_low_routed[k] && pwm_low_en[k]) begin
				drive_nxt[k+PIN_UPPER] = 1'b1;
				value_nxt[k+PIN_UPPER] = pwm_low_out[k];
			end
		end
	end

	pspc_pad #(
		.WIDTH(WIDTH)
	) u_pad (
		.drive_out(drive_nxt),
		.out_value(value_nxt),
		.open_drain(open_drain_r | force_od_nxt),
		.pull_enable(pull_enable_r),
		.pull_polarity(pull_polarity_r),
		.pad_out(pad_out_w),
		.pad_oe(pad_oe_w),
		.pad_pull_up(pad_pu_w),
		.pad_pull_dn(pad_pd_w)
	);

	// pad controls leave through flip-flops, one cycle behind the config
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_out <= {WIDTH{1'b0}};
			pin_oe <= {WIDTH{1'b0}};
			pin_pull_up <= {WIDTH{1'b0}};
			pin_pull_dn <= {WIDTH{1'b0}};
			pin_sync <= {WIDTH{1'b0}};
		end else begin
			pin_out <= pad_out_w;
			pin_oe <= pad_oe_w;
			pin_pull_up <= pad_pu_w;
			pin_pull_dn <= pad_pd_w;
			pin_sync <= pin_s;
		end
	end

	// routing decode for the neighbouring ports
	always @(posedge clk) begin
		if (sys_rst) begin
			iic_on_port_s <= 1'b0;
			iic_on_port_r <= 1'b0;
			iic_on_port_v <= 1'b0;
			spi_on_port_s <= 1'b0;
			spi_on_port_h <= 1'b0;
			spi_on_port_v <= 1'b0;
			spi_route_reserved <= 1'b0;
		end else begin
			// iic codes 00 and 01 both mean port s
			iic_on_port_s <= !iic_route[1];
			iic_on_port_r <= (iic_route == `PSPC_IIC_PORT_R);
			iic_on_port_v <= (iic_route == `PSPC_IIC_PORT_V);
			spi_on_port_s <= (spi_route == `PSPC_SPI_PORT_S);
			spi_on_port_h <= (spi_route == `PSPC_SPI_PORT_H);
			spi_on_port_v <= (spi_route == `PSPC_SPI_PORT_V);
			// reserved code places spi nowhere
			spi_route_reserved <= (spi_route == `PSPC_SPI_RESERVED);
		end
	end

	// edge detection on synchronised pins
	assign rise_seen = pin_s & ~pin_prev_r;
	assign fall_seen = ~pin_s & pin_prev_r;
	// polarity picks which edge counts, the same bit that picks the pull
	assign edge_seen = (pull_polarity_r & rise_seen)
		| (~pull_polarity_r & fall_seen);
	assign flag_clear = wr_hit_flag ? reg_wdata : {WIDTH{1'b0}};

	// a new edge beats a write-one-to-clear in the same cycle
	always @* begin
		edge_flag_nxt = (edge_flag_r & ~flag_clear) | edge_seen;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			pin_prev_r <= {WIDTH{1'b0}};
			edge_flag_r <= `PSPC_RST_EDGE_FLAG;
			irq <= 1'b0;
		end else begin
			pin_prev_r <= pin_s;
			edge_flag_r <= edge_flag_nxt;
			// built from the next flag value so irq rises together with the flag
			irq <= |(edge_flag_nxt & irq_mask_r);
		end
	end

	// read mux; data appears the cycle after the strobe
	always @* begin
		rdata_nxt = {`PSPC_DATA_W{1'b0}};
		case (reg_addr)
		`PSPC_OFS_DATA: begin
			rdata_nxt = (direction_r & data_r) | (~direction_r & pin_s);
		end
		`PSPC_OFS_INPUT: begin
			rdata_nxt = pin_s;
		end
		`PSPC_OFS_DIRECTION: begin
			rdata_nxt = direction_r;
		end
		`PSPC_OFS_PULL_ENABLE: begin
			rdata_nxt = pull_enable_r;
		end
		`PSPC_OFS_PULL_POLARITY: begin
			rdata_nxt = pull_polarity_r;
		end
		`PSPC_OFS_OPEN_DRAIN: begin
			rdata_nxt = open_drain_r;
		end
		`PSPC_OFS_ROUTING: begin
			rdata_nxt = routing_r;
		end
		`PSPC_OFS_EDGE_FLAG: begin
			rdata_nxt = edge_flag_r;
		end
		`PSPC_OFS_IRQ_MASK: begin
			rdata_nxt = irq_mask_r;
		end
		default: begin
			rdata_nxt = {`PSPC_DATA_W{1'b0}};
		end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= {`PSPC_DATA_W{1'b0}};
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			// data stand only in the cycle after the read strobe
			reg_rdata <= {`PSPC_DATA_W{1'b0}};
		end
	end

endmodule

/* File: verif/pspc_properties.sv */
/*
 checker for the port s pin block: overrides, pulls, sync delay, read data.
 assumes it is bound to pspc_top and every input is on clk.
*/
`timescale 1ns/10ps
`include "pspc_regs.vh"
module pspc_props #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register read side
	input wire reg_rd,
	input wire [`PSPC_DATA_W-1:0] reg_rdata,
	// pins
	input wire [WIDTH-1:0] pin_in,
	input wire [WIDTH-1:0] pin_oe,
	input wire [WIDTH-1:0] pin_pull_up,
	input wire [WIDTH-1:0] pin_pull_dn,
	input wire [WIDTH-1:0] pin_sync,
	// peripheral enables and the interrupt
	input wire can_en,
	input wire serial_comm_interface_en,
	input wire pwm_channel_seven_routed,
	input wire pwm_channel_seven_shutdown,
	input wire pwm_channel_six_routed,
	input wire pwm_channel_six_en,
	input wire irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire serial_comm_interface = serial_comm_interface_en;
	// pulls show an input pin even when open-drain hides the drive
	wire [WIDTH-1:0] pulled = pin_pull_up | pin_pull_dn;
	reg [1:0] up_r;
	always @(posedge clk) begin
		if (sys_rst)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	end
	can_out_a: assert property (can_en |=> !pulled[3])
		else $error("pin 3 not output under can");
	can_in_a: assert property (can_en |=> !pin_oe[2])
		else $error("pin 2 driven under can");
	sci_tx_a: assert property (serial_comm_interface |=> !pulled[1])
		else $error("pin 1 not output under serial");
	pwm_channel_seven_out_a: assert property (!serial_comm_interface && pwm_channel_seven_routed
		&& !pwm_channel_seven_shutdown |=> !pulled[1])
		else $error("pin 1 not output for pwm_channel_seven");
	shutdown_in_a: assert property (!serial_comm_interface && pwm_channel_seven_routed
		&& pwm_channel_seven_shutdown |=> !pin_oe[1])
		else $error("pin 1 driven in shutdown mode");
	sci_rx_a: assert property (serial_comm_interface |=> !pin_oe[0])
		else $error("pin 0 driven under serial");
	pwm_channel_six_out_a: assert property (!serial_comm_interface && pwm_channel_six_routed
		&& pwm_channel_six_en |=> !pulled[0])
		else $error("pin 0 not output for pwm_channel_six");
	pull_input_a: assert property ((pin_oe & pulled) == 8'h00)
		else $error("pull active on a driven pin");
	pull_side_a: assert property ((pin_pull_up & pin_pull_dn) == 8'h00)
		else $error("pull-up and pull-down together");
	sync_delay_a: assert property (up_r == 2'h3 |-> pin_sync == $past(pin_in, 3))
		else $error("pin sync delay wrong");
	read_stands_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	cover property (can_en ##1 pin_oe[3]);
	cover property (pwm_channel_seven_routed && pwm_channel_seven_shutdown);
	cover property ($rose(irq));
endmodule
bind pspc_top pspc_props #(.WIDTH(WIDTH)) props_u (.clk(clk), .sys_rst(sys_rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_oe(pin_oe),
	.pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .pin_sync(pin_sync),
	.can_en(can_en), .serial_comm_interface_en(serial_comm_interface_en),
	.pwm_channel_seven_routed(pwm_channel_seven_routed),
	.pwm_channel_seven_shutdown(pwm_channel_seven_shutdown),
	.pwm_channel_six_routed(pwm_channel_six_routed),
	.pwm_channel_six_en(pwm_channel_six_en), .irq(irq));

/* File: verif/pspc_pins.sv */
/*
 outside world of port s: resolves each pin from pad drive, outside drivers and pulls.
 assumes outside drivers never fight a driving pad.
*/
`timescale 1ns/10ps
module pspc_pins (
	// clock for the floating pattern
	input wire clk,
	// pad controls
	input wire [7:0] pad_out,
	input wire [7:0] pad_oe,
	input wire [7:0] pad_pu,
	input wire [7:0] pad_pd,
	// outside drivers
	input wire [7:0] ext_drv,
	input wire [7:0] ext_level,
	// resolved levels
	output wire [7:0] pin_level
);
	// an undriven, unpulled pin toggles so a stale level is never read as valid
	reg float_r = 1'h0;
	wire [7:0] idle = ~pad_oe & ~ext_drv;
	always @(posedge clk)
		float_r <= ~float_r;
	assign pin_level = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_level)
		| (idle & (pad_pu | (~pad_pd & {8{float_r}})));
endmodule

/* File: verif/test_port_s_pin_config_routing.sv */
/*
 self-checking bench for pspc_top: registers, overrides, pads, routing, flags and irq.
 assumes pspc_pins models the board; expected results queue up for the monitor.
*/
`timescale 1ns/10ps
module test_port_s_pin_config_routing;
	reg clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_seen = 1'h0, sn = 1'h0;
	reg [3:0] reg_addr = 4'h0, pwm_en = 4'hf;
	reg [7:0] reg_wdata = 8'h00, ext_drv = 8'h00, ext_lvl = 8'h00, v;
	reg [11:0] per = 12'h000, vals = 12'h000, e;
	reg [11:0] q[$];
	reg [27:0] tbl [0:8] = '{28'h048_0008, 28'h014_0002, 28'h002_0002, 28'h023_0000,
		28'h000_c001, 28'h007_c002, 28'h000_3f50, 28'h000_1f70, 28'h000_0ff0};
	wire [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn;
	wire [6:0] route;
	wire irq;
	int i, mismatches = 0, total_checks = 0;
	pspc_top #(.WIDTH(8)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
		.pin_pull_dn(pin_pull_dn), .pin_sync(), .can_en(per[11]), .can_tx(vals[0]),
		.serial_comm_interface_en(per[10]), .serial_comm_interface_txd(vals[1]),
		.pwm_channel_seven_routed(per[9]), .pwm_channel_seven_shutdown(per[8]),
		.pwm_channel_seven_out(vals[2]), .pwm_channel_six_routed(per[7]),
		.pwm_channel_six_en(per[6]), .pwm_channel_six_out(vals[3]), .spi_en(per[5]),
		.spi_oe(4'h5), .spi_out(vals[7:4]), .iic_en(per[4]), .iic_scl_out(1'h0),
		.iic_sda_out(1'h1), .pwm_low_routed(per[3:0]), .pwm_low_en(pwm_en),
		.pwm_low_out(vals[11:8]), .iic_on_port_s(route[6]), .iic_on_port_r(route[5]),
		.iic_on_port_v(route[4]), .spi_on_port_s(route[3]), .spi_on_port_h(route[2]),
		.spi_on_port_v(route[1]), .spi_route_reserved(route[0]), .irq(irq));
	pspc_pins pins_u (.clk(clk), .pad_out(pin_out), .pad_oe(pin_oe), .pad_pu(pin_pull_up),
		.pad_pd(pin_pull_dn), .ext_drv(ext_drv), .ext_level(ext_lvl), .pin_level(pin_in));
	initial forever #5 clk = ~clk;
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input [7:0] x, input [7:0] g);
		total_checks++;
		if (g !== x) begin
			mismatches++;
			$display("Error at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input [3:0] a, input [7:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		q.push_back({4'h0, x});
		@(posedge clk);
		reg_rd <= 1'h0;
	endtask
	// kinds: 1 oe, 2 out, 3 pull-up, 4 pull-down, 5 routing, 6 irq
	task snap(input [3:0] k, input [7:0] x);
		@(posedge clk);
		q.push_back({k, x});
		sn <= 1'h1;
		@(posedge clk);
		sn <= 1'h0;
	endtask
	always @(posedge clk)
		rd_seen <= reg_rd;
	always @(negedge clk) begin
		if (rd_seen | sn) begin
			e = q.pop_front();
			case (e[11:8])
			4'h0: cmp(e[7:0], reg_rdata);
			4'h1: cmp(e[7:0], pin_oe);
			4'h2: cmp(e[7:0], pin_out);
			4'h3: cmp(e[7:0], pin_pull_up);
			4'h4: cmp(e[7:0], pin_pull_dn);
			4'h5: cmp(e[7:0], {1'h0, route});
			default: cmp(e[7:0], {7'h00, irq});
			endcase
		end
	end
	initial begin
		#200000;
		mismatches++;
		close_out;
	end
	initial begin
		void'($urandom(32'h0f34d7a7));
		repeat (16) @(posedge clk);
		sys_rst <= 1'h0;
		rd(4'h2, 8'h00);
		rd(4'h3, 8'hff);
		rd(4'h4, 8'h00);
		rd(4'h9, 8'h00);
		snap(4'h3, 8'hff);
		for (i = 2; i < 6; i++) begin
			v = $urandom;
			wr(i[3:0], v);
			rd(i[3:0], v);
		end
		wr(4'h6, 8'hff);
		rd(4'h6, 8'h33);
		for (i = 0; i < 4; i++) begin
			wr(4'h6, {2'h0, i[1:0], 2'h0, i[1:0]});
			snap(4'h5, {1'h0, i < 2, i == 2, i == 3, 4'h8 >> i});
		end
		wr(4'h6, 8'h00);
		wr(4'h5, 8'h00);
		v = $urandom;
		wr(4'h2, v);
		wr(4'h3, 8'hff);
		wr(4'h4, 8'h00);
		snap(4'h1, v);
		snap(4'h3, ~v);
		wr(4'h4, 8'hff);
		snap(4'h4, ~v);
		v = $urandom;
		wr(4'h0, v);
		wr(4'h2, 8'hff);
		wr(4'h5, 8'hff);
		snap(4'h1, ~v);
		snap(4'h2, 8'h00);
		wr(4'h5, 8'h00);
		snap(4'h1, 8'hff);
		snap(4'h2, v);
		rd(4'h0, v);
		wr(4'h2, 8'h00);
		wr(4'h5, 8'hff);
		snap(4'h1, 8'h00);
		snap(4'h4, 8'hff);
		wr(4'h5, 8'h00);
		wr(4'h4, 8'h00);
		for (i = 0; i < 9; i++) begin
			wr(4'h2, tbl[i][27:20]);
			per <= tbl[i][19:8];
			vals <= $urandom;
			snap(4'h1, tbl[i][7:0]);
		end
		per <= 12'h00f;
		pwm_en <= 4'h5;
		snap(4'h1, 8'h50);
		per <= 12'h000;
		ext_drv <= 8'hff;
		ext_lvl <= 8'h00;
		wr(4'h3, 8'h00);
		wr(4'h4, 8'hff);
		repeat (6) @(posedge clk);
		wr(4'h7, 8'hff);
		rd(4'h7, 8'h00);
		ext_lvl <= 8'h20;
		repeat (3) @(posedge clk);
		rd(4'h1, 8'h20);
		rd(4'h7, 8'h20);
		rd(4'h0, 8'h20);
		snap(4'h6, 8'h00);
		wr(4'h8, 8'h20);
		snap(4'h6, 8'h01);
		wr(4'h7, 8'h20);
		rd(4'h7, 8'h00);
		snap(4'h6, 8'h00);
		wr(4'h4, 8'h00);
		ext_lvl <= 8'h00;
		repeat (5) @(posedge clk);
		rd(4'h7, 8'h20);
		repeat (2) @(posedge clk);
		if (q.size() != 0)
			mismatches++;
		close_out;
	end
endmodule
